// ### src/asrc_defs.vh
// Constants of the polyphase sample rate converter core
`ifndef ASRC_DEFS_VH
`define ASRC_DEFS_VH
`define CLOCK_HZ 100000000
`define INTERP_BITS 16
`define INTERPOLATION_FACTOR 65536
`define PROTO_TAPS 4194304
`define TAPS_PER_PHASE 64
`define PASSBAND_HZ 20000
`define FINE_GRID_PS 300
`define CONV_RATE_HZ 3276800000
`define FIFO_ABITS 5
`define FIFO_DEPTH 32
`define POINTER_GAP 5
`define SAMPLE_BITS 16
`define COEF_BITS 22
`define ACC_BITS 27
`define SLOW_SETTLE_MS 800
`define FAST_SETTLE_MS 200
`define SLOW_SHIFT 12
`define FAST_SHIFT 10
`define PERIOD_BITS 24
`define ACC_RESET 27'h0000000
`endif

// ### src/asrc_polyphase_core.v
// Stereo asynchronous sample rate converter core with servo-tracked polyphase selection
`include "asrc_defs.vh"
module asrc_polyphase_core (
   input wire clock,
   input wire rst,
   input wire input_frame_clock,
   input wire output_frame_clock,
   input wire slow_settle_select,
   input wire zero_output_request,
   input wire [`SAMPLE_BITS-1:0] left_in,
   input wire [`SAMPLE_BITS-1:0] right_in,
   output reg [`SAMPLE_BITS-1:0] left_out,
   output reg [`SAMPLE_BITS-1:0] right_out,
   output reg out_valid,
   output reg collision,
   output reg [`FIFO_ABITS-1:0] fifo_start,
   output reg [`INTERP_BITS-1:0] coef_start
);
   localparam AW = `FIFO_ABITS;
   localparam PB = `PERIOD_BITS;
   localparam CW = `COEF_BITS;
   localparam AC = `ACC_BITS;
   localparam TAPS = `TAPS_PER_PHASE;
   localparam S_IDLE = 3'b001;
   localparam S_RUN = 3'b010;
   localparam S_DONE = 3'b100;

   // Three-stage synchronisers
   reg [2:0] ifc_s;
   reg [2:0] ofc_s;
   reg [2:0] sel_s;
   reg ifc_q;
   reg ofc_q;
   reg slow_mode;
   always @(posedge clock) begin
      if (rst) begin
         ifc_s <= 3'h0;
         ofc_s <= 3'h0;
         sel_s <= 3'h0;
         ifc_q <= 1'b0;
         ofc_q <= 1'b0;
         slow_mode <= 1'b0;
      end else begin
         ifc_s <= {ifc_s[1:0], input_frame_clock};
         ofc_s <= {ofc_s[1:0], output_frame_clock};
         sel_s <= {sel_s[1:0], slow_settle_select};
         if (ifc_s[1] == ifc_s[2]) begin
            ifc_q <= ifc_s[2];
         end
         if (ofc_s[1] == ofc_s[2]) begin
            ofc_q <= ofc_s[2];
         end
         if (sel_s[1] == sel_s[2]) begin
            slow_mode <= sel_s[2];
         end
      end
   end
   wire ifc_agree = (ifc_s[1] == ifc_s[2]);
   wire ofc_agree = (ofc_s[1] == ofc_s[2]);
   wire in_event = ifc_agree && ifc_s[2] && !ifc_q;
   wire out_event = ofc_agree && ofc_s[2] && !ofc_q;

   // Input period measurement and write counter
   reg [PB-1:0] since_in;
   reg [AW-1:0] write_addr;
   reg primed;
   always @(posedge clock) begin
      if (rst) begin
         since_in <= 24'h000000;
         write_addr <= 5'h00;
         primed <= 1'b0;
      end else if (in_event) begin
         since_in <= 24'h000001;
         write_addr <= write_addr + 5'h01;
         primed <= 1'b1;
      end else if (since_in != 24'hFFFFFF) begin
         since_in <= since_in + 24'h000001;
      end
   end

   // Servo loop: first-order smoothing of input period, shift picks settling
   reg [PB+15:0] period_acc;
   reg seeded;
   wire [PB-1:0] period_est = period_acc[PB+15:16];
   wire [4:0] loop_shift = slow_mode ? 5'd`SLOW_SHIFT : 5'd`FAST_SHIFT;
   wire signed [PB+16:0] period_err = $signed({1'b0, since_in, 16'h0000})
      - $signed({1'b0, period_acc});
   wire signed [PB+16:0] period_step = period_err >>> loop_shift;
   always @(posedge clock) begin
      if (rst) begin
         period_acc <= 40'h0000000000;
         seeded <= 1'b0;
      end else if (in_event && primed) begin
         // First full period seeds the loop so the phase is usable at once
         if (!seeded) begin
            period_acc <= {since_in, 16'h0000};
         end else begin
            period_acc <= period_acc + period_step[PB+15:0];
         end
         seeded <= 1'b1;
      end
   end

   // Phase: fraction of period elapsed at output event, 16 bits
   wire [PB+15:0] num = {since_in, 16'h0000};
   wire [PB-1:0] den = (period_est == 24'h000000) ? 24'h000001 : period_est;
   wire [PB+15:0] quot = num / {16'h0000, den};
   wire [`INTERP_BITS-1:0] phase = (quot[PB+15:16] != 24'h000000) ?
      16'hFFFF : quot[15:0];

   // Start address generation; read pointer kept gap behind writes
   reg [AW-1:0] read_base;
   reg [AW-1:0] target;
   always @* begin
      target = write_addr - 5'd`POINTER_GAP;
   end
   wire [AW-1:0] step = target - read_base;
   always @(posedge clock) begin
      if (rst) begin
         read_base <= 5'h00;
         fifo_start <= 5'h00;
         coef_start <= 16'h0000;
         collision <= 1'b0;
      end else if (out_event && primed) begin
         read_base <= target;
         fifo_start <= target;
         coef_start <= phase;
         // Hold, advance one or advance two; larger gaps mean under/overflow
         collision <= !(step == 5'h00 || step == 5'h01 || step == 5'h02);
      end
   end

   // Sample storage
   wire [2*`SAMPLE_BITS-1:0] rd_raw;
   reg [AW-1:0] rd_addr;
   // Locations written since reset; unwritten ones read as silence
   reg [`FIFO_DEPTH-1:0] filled;
   reg word_ok;
   wire [2*`SAMPLE_BITS-1:0] rd_word = word_ok ? rd_raw : 32'h00000000;
   always @(posedge clock) begin
      if (rst) begin
         filled <= 32'h00000000;
         word_ok <= 1'b0;
      end else begin
         if (in_event) begin
            filled[write_addr] <= 1'b1;
         end
         word_ok <= filled[rd_addr];
      end
   end
   sample_ram #(.AW(AW), .DW(2*`SAMPLE_BITS)) store (
      .clock(clock),
      .write_enable(in_event),
      .write_address(write_addr),
      .write_data({left_in, right_in}),
      .read_address(rd_addr),
      .read_data(rd_raw)
   );

   // Convolution: 64 taps of selected subfilter; coefficient from prototype
   // triangular window, indexed with large offset for late phase
   reg [2:0] state;
   reg [6:0] tap;
   reg [AC-1:0] acc_l;
   reg [AC-1:0] acc_r;
   reg [CW-1:0] coef;
   reg [21:0] pos;
   always @* begin
      pos = {tap[5:0], 16'h0000} + {6'h00, coef_start};
      if (pos[21]) begin
         coef = 22'h3FFFFF - {pos[20:0], 1'b0};
      end else begin
         coef = {pos[20:0], 1'b0};
      end
   end
   wire signed [CW:0] coef_s = $signed({1'b0, coef});
   wire signed [CW+16:0] prod_l = $signed(rd_word[31:16]) * coef_s;
   wire signed [CW+16:0] prod_r = $signed(rd_word[15:0]) * coef_s;
   wire [AC-1:0] scaled_l = prod_l[CW+16:CW+16-AC+1];
   wire [AC-1:0] scaled_r = prod_r[CW+16:CW+16-AC+1];
   reg conv_go;
   always @(posedge clock) begin
      if (rst) begin
         conv_go <= 1'b0;
      end else begin
         conv_go <= out_event && primed;
      end
   end
   always @(posedge clock) begin
      if (rst) begin
         state <= S_IDLE;
         tap <= 7'h00;
         rd_addr <= 5'h00;
         acc_l <= `ACC_RESET;
         acc_r <= `ACC_RESET;
         left_out <= 16'h0000;
         right_out <= 16'h0000;
         out_valid <= 1'b0;
      end else begin
         out_valid <= 1'b0;
         case (state)
            S_IDLE: begin
               if (conv_go) begin
                  rd_addr <= fifo_start;
                  tap <= 7'h00;
                  acc_l <= `ACC_RESET;
                  acc_r <= `ACC_RESET;
                  state <= S_RUN;
               end
            end
            S_RUN: begin
               rd_addr <= rd_addr - 5'h01;
               if (tap != 7'h00) begin
                  acc_l <= acc_l + scaled_l;
                  acc_r <= acc_r + scaled_r;
               end
               tap <= tap + 7'h01;
               if (tap == TAPS[6:0]) begin
                  state <= S_DONE;
               end
            end
            S_DONE: begin
               left_out <= zero_output_request ? 16'h0000 : acc_l[AC-2:AC-17];
               right_out <= zero_output_request ? 16'h0000 : acc_r[AC-2:AC-17];
               out_valid <= 1'b1;
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// ### src/sample_ram.v
// Dual-port sample store with registered read data
module sample_ram #(
   parameter AW = 5,
   parameter DW = 32
) (
   input wire clock,
   input wire write_enable,
   input wire [AW-1:0] write_address,
   input wire [DW-1:0] write_data,
   input wire [AW-1:0] read_address,
   output reg [DW-1:0] read_data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   always @(posedge clock) begin
      if (write_enable) begin
         mem[write_address] <= write_data;
      end
      read_data <= mem[read_address];
   end
endmodule

// ### test/asrc_core_checker_sva.sv
// Port assertions for the rate converter core
`include "asrc_defs.vh"
module asrc_core_checker (
   input wire clock,
   input wire rst,
   input wire output_frame_clock,
   input wire zero_output_request,
   input wire [`SAMPLE_BITS-1:0] left_out,
   input wire [`SAMPLE_BITS-1:0] right_out,
   input wire out_valid,
   input wire collision,
   input wire [`FIFO_ABITS-1:0] fifo_start,
   input wire [`INTERP_BITS-1:0] coef_start
);
   reg primed;
   always @(posedge clock)
      primed <= rst ? 1'b0 : primed | out_valid;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   AST_RESET_CLEAR: assert property (disable iff (1'b0)
      rst |=> {collision, out_valid, fifo_start, coef_start, left_out, right_out} == 55'h0)
      else $error("outputs not cleared");
   AST_QUIET_AFTER_RESET: assert property ($fell(rst) |-> !out_valid [*8])
      else $error("early sample");
   AST_VALID_PULSE: assert property (out_valid |=> !out_valid)
      else $error("long out_valid");
   AST_SAMPLES_HOLD: assert property (
      !out_valid |-> $stable(left_out) && $stable(right_out)) else $error("samples moved");
   AST_MUTED_SAMPLES: assert property (
      out_valid && zero_output_request && $past(zero_output_request)
      && $past(zero_output_request, 2) |-> {left_out, right_out} == 32'h0)
      else $error("muted samples not zero");
   AST_START_ON_EVENT: assert property (
      $changed(fifo_start) || $changed(coef_start) || $changed(collision)
      |-> $past(output_frame_clock, 3)) else $error("start moved without event");
   AST_SYNC_DELAY: assert property (
      $rose(output_frame_clock) |=> ($stable(fifo_start) && $stable(coef_start)) [*2])
      else $error("event used unsynchronised");
   AST_READ_STEP: assert property (
      primed && $changed(fifo_start) |-> collision || 5'(fifo_start - $past(fifo_start)) <= 5'h02)
      else $error("read step out of range");
   AST_ANSWER_TIME: assert property (out_valid |-> $past(output_frame_clock, 60))
      else $error("sample without request");
endmodule

// ### test/frame_source.sv
// Audio source and sink model making both frame clocks and input samples
module frame_source (
   output logic input_frame_clock,
   output logic output_frame_clock,
   output logic [15:0] left_in,
   output logic [15:0] right_in
);
   timeunit 1ns;
   timeprecision 100ps;
   int lag = 400;
   initial begin
      input_frame_clock = 1'b0;
      output_frame_clock = 1'b0;
      left_in = 16'h1000;
      right_in = 16'h2000;
   end
   // Input events every 1600 ns, samples change away from the rising edge
   always begin
      #800 input_frame_clock = 1'b1;
      #800 input_frame_clock = 1'b0;
      left_in = left_in + 16'h0101;
      right_in = right_in - 16'h0101;
   end
   // Output request follows each input event by a set lag
   always @(posedge input_frame_clock) fork
      #(lag) output_frame_clock = 1'b1;
      #(lag + 800) output_frame_clock = 1'b0;
   join_none
endmodule

// ### test/testbench.sv
// Self-checking bench for the rate converter core
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic zero_output_request = 1'b0;
   logic slow_settle_select = 1'b0;
   wire input_frame_clock, output_frame_clock, out_valid, collision;
   wire [15:0] left_in, right_in, left_out, right_out, coef_start;
   wire [4:0] fifo_start;
   int bad_count = 0;
   int comparisons = 0;
   logic [15:0] early;
   asrc_polyphase_core i_asrc_polyphase_core (.clock(clock), .rst(rst),
      .input_frame_clock(input_frame_clock), .output_frame_clock(output_frame_clock),
      .slow_settle_select(slow_settle_select), .zero_output_request(zero_output_request),
      .left_in(left_in), .right_in(right_in), .left_out(left_out), .right_out(right_out),
      .out_valid(out_valid), .collision(collision), .fifo_start(fifo_start),
      .coef_start(coef_start));
   frame_source model (.input_frame_clock(input_frame_clock),
      .output_frame_clock(output_frame_clock), .left_in(left_in), .right_in(right_in));
   initial forever #5 clock = ~clock;
   task automatic check(string what, logic [54:0] exp, logic [54:0] seen);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_valid(int n);
      int t = 0;
      while (n > 0 && t < 4000) begin
         @(negedge clock);
         t++;
         if (out_valid === 1'b1) n--;
      end
      check("pulses missing", 0, n);
   endtask
   task automatic t_reset;
      repeat (4) @(negedge clock);
      check("outputs", 0, {collision, out_valid, fifo_start, coef_start, left_out, right_out});
      rst = 1'b0;
   endtask
   task automatic t_count;
      int rises = 0;
      int pulses = 0;
      logic last;
      wait_valid(3);
      last = output_frame_clock;
      repeat (3280) begin
         @(negedge clock);
         rises += (output_frame_clock && !last);
         pulses += out_valid;
         last = output_frame_clock;
      end
      check("pulse count", rises, pulses);
      check("collision", 0, collision);
   endtask
   task automatic t_zero;
      zero_output_request = 1'b1;
      wait_valid(2);
      check("muted", 0, {left_out, right_out});
      zero_output_request = 1'b0;
      wait_valid(2);
      check("live", 1, |left_out);
   endtask
   task automatic t_phase;
      model.lag = 250;
      wait_valid(12);
      early = coef_start;
      model.lag = 1050;
      wait_valid(12);
      check("late phase above early", 1, coef_start > early);
   endtask
   task automatic t_settle;
      slow_settle_select = 1'b1;
      wait_valid(8);
      check("collision slow", 0, collision);
      slow_settle_select = 1'b0;
      wait_valid(4);
   endtask
   task automatic results;
      if (bad_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      t_reset();
      t_count();
      t_zero();
      t_phase();
      t_settle();
      results();
   end
   initial begin
      repeat (40000) @(posedge clock);
      bad_count++;
      results();
   end
endmodule
bind asrc_polyphase_core asrc_core_checker i_chk (.clock(clock), .rst(rst),
   .output_frame_clock(output_frame_clock), .zero_output_request(zero_output_request),
   .left_out(left_out), .right_out(right_out), .out_valid(out_valid),
   .collision(collision), .fifo_start(fifo_start), .coef_start(coef_start));
